/* File: core/tmw_timer.sv */
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
module tmw_timer (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [tmw_pkg::TMW_ADDR_W-1:0] reg_addr_i,
    input wire logic [tmw_pkg::TMW_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [tmw_pkg::TMW_DATA_W-1:0] reg_rdata_o,
    output logic wave_out_o,
    output logic wave_oe_o,
    output logic overflow_flag_o,
    output logic compare_flag_o
);
    import tmw_pkg::*;

    // =====================================================
    // register decode
    tmw_ctrl_s ctrl_r;
    logic [7:0] count_value_r;
    logic [7:0] cnt_nxt;
    logic [7:0] compare_value_r;
    logic [7:0] cmp_buf_r;
    logic overflow_flag_r;
    logic compare_flag_r;
    logic pin_dir_r;
    logic wave_out_r;
    logic wave_nxt;
    logic block_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    tmw_dir_e dir_r;
    tmw_dir_e dir_nxt;
    logic tick;
    logic wr_ctrl;
    logic wr_count;
    logic wr_cmp;
    logic wr_flags;
    logic wr_pin;
    logic force_pulse;
    logic pwm_mode;
    logic match_ok;
    logic ovf_evt;
    logic cmp_evt;
    logic load_evt;
    logic step;
    logic up_level;
    tmw_mode_e mode;
    logic [1:0] act;

    assign wr_ctrl = reg_wr_i && (reg_addr_i == TMW_ADDR_CTRL);
    assign wr_count = reg_wr_i && (reg_addr_i == TMW_ADDR_COUNT);
    assign wr_cmp = reg_wr_i && (reg_addr_i == TMW_ADDR_COMPARE);
    assign wr_flags = reg_wr_i && (reg_addr_i == TMW_ADDR_FLAGS);
    assign wr_pin = reg_wr_i && (reg_addr_i == TMW_ADDR_PINDIR);
    assign force_pulse = wr_ctrl && reg_wdata_i[TMW_FORCE_BIT];
    assign mode = ctrl_r.wave_mode_sel;
    assign act = ctrl_r.out_action_sel;
    assign pwm_mode = (mode == TMW_MODE_PHASE) || (mode == TMW_MODE_FAST);
    // a software count write takes priority over any count step
    assign step = tick && !wr_count;

    tmw_prescaler #(
        .DIV_W(TMW_DIV_W)
    ) u_prescaler (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_sel_i(ctrl_r.clk_sel),
        .tick_o(tick)
    );

    // force bit is a strobe and is never stored
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_r <= TMW_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= tmw_ctrl_s'({1'b0, reg_wdata_i[6:0]});
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_dir_r <= 1'b0;
        end else if (wr_pin) begin
            pin_dir_r <= reg_wdata_i[TMW_PINDIR_BIT];
        end
    end

    // =====================================================
    // counter sequence, chosen by mode alone
    assign match_ok = (count_value_r == compare_value_r) && !block_r;

    always_comb begin
        cnt_nxt = 8'(count_value_r + TMW_ONE);
        dir_nxt = dir_r;
        case (mode)
            TMW_MODE_NORMAL: cnt_nxt = 8'(count_value_r + TMW_ONE);
            TMW_MODE_CLEAR: begin
                if (match_ok) begin
                    cnt_nxt = TMW_BOTTOM;
                end
            end
            TMW_MODE_FAST: cnt_nxt = 8'(count_value_r + TMW_ONE);
            TMW_MODE_PHASE: begin
                if (count_value_r == TMW_MAX) begin
                    cnt_nxt = 8'(TMW_MAX - TMW_ONE);
                    dir_nxt = TMW_DIR_DOWN;
                end else if (count_value_r == TMW_BOTTOM) begin
                    cnt_nxt = TMW_ONE;
                    dir_nxt = TMW_DIR_UP;
                end else begin
                    case (dir_r)
                        TMW_DIR_UP: cnt_nxt = 8'(count_value_r + TMW_ONE);
                        TMW_DIR_DOWN: cnt_nxt = 8'(count_value_r - TMW_ONE);
                        default: cnt_nxt = count_value_r;
                    endcase
                end
            end
            default: cnt_nxt = count_value_r;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count_value_r <= TMW_COUNT_RST;
        end else if (wr_count) begin
            count_value_r <= reg_wdata_i;
        end else if (tick) begin
            count_value_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dir_r <= TMW_DIR_UP;
        end else if (mode != TMW_MODE_PHASE) begin
            dir_r <= TMW_DIR_UP;
        end else if (step) begin
            dir_r <= dir_nxt;
        end
    end

    // a count write hides the match of the next tick, so equal
    // compare and count can be preloaded without an event
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            block_r <= 1'b0;
        end else if (wr_count) begin
            block_r <= 1'b1;
        end else if (tick) begin
            block_r <= 1'b0;
        end
    end

    // =====================================================
    // compare register and its buffer
    always_comb begin
        case (mode)
            TMW_MODE_FAST: load_evt = step && (count_value_r == TMW_MAX);
            TMW_MODE_PHASE: load_evt = step && (count_value_r == 8'(TMW_MAX - TMW_ONE))
                && (dir_r == TMW_DIR_UP);
            default: load_evt = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmp_buf_r <= TMW_COMPARE_RST;
        end else if (wr_cmp) begin
            cmp_buf_r <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            compare_value_r <= TMW_COMPARE_RST;
        end else if (wr_cmp && !pwm_mode) begin
            compare_value_r <= reg_wdata_i;
        end else if (load_evt) begin
            compare_value_r <= cmp_buf_r;
        end
    end

    // =====================================================
    // flags: a set in the clearing cycle wins
    always_comb begin
        case (mode)
            TMW_MODE_PHASE: ovf_evt = step && (count_value_r == TMW_ONE)
                && (dir_r == TMW_DIR_DOWN);
            TMW_MODE_FAST: ovf_evt = step && (count_value_r == 8'(TMW_MAX - TMW_ONE));
            default: ovf_evt = step && (count_value_r == TMW_MAX);
        endcase
    end

    assign cmp_evt = step && match_ok;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            overflow_flag_r <= 1'b0;
        end else if (ovf_evt) begin
            overflow_flag_r <= 1'b1;
        end else if (wr_flags && reg_wdata_i[TMW_FLAG_OVF_BIT]) begin
            overflow_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            compare_flag_r <= 1'b0;
        end else if (cmp_evt) begin
            compare_flag_r <= 1'b1;
        end else if (wr_flags && reg_wdata_i[TMW_FLAG_CMP_BIT]) begin
            compare_flag_r <= 1'b0;
        end
    end

    // =====================================================
    // waveform generator
    // phase correct: at max use the down result, at bottom the up result,
    // which keeps the extreme compare values at a steady level
    assign up_level = (act == TMW_ACT_SET);

    always_comb begin
        wave_nxt = wave_out_r;
        if (force_pulse && !pwm_mode) begin
            case (act)
                TMW_ACT_TOGGLE: wave_nxt = !wave_out_r;
                TMW_ACT_CLEAR: wave_nxt = 1'b0;
                TMW_ACT_SET: wave_nxt = 1'b1;
                default: wave_nxt = wave_out_r;
            endcase
        end else if (step) begin
            case (mode)
                TMW_MODE_NORMAL, TMW_MODE_CLEAR: begin
                    if (match_ok) begin
                        case (act)
                            TMW_ACT_TOGGLE: wave_nxt = !wave_out_r;
                            TMW_ACT_CLEAR: wave_nxt = 1'b0;
                            TMW_ACT_SET: wave_nxt = 1'b1;
                            default: wave_nxt = wave_out_r;
                        endcase
                    end
                end
                TMW_MODE_FAST: begin
                    case (act)
                        TMW_ACT_TOGGLE: begin
                            if (match_ok) begin
                                wave_nxt = !wave_out_r;
                            end
                        end
                        TMW_ACT_CLEAR, TMW_ACT_SET: begin
                            // bottom wins over match, so compare max stays flat
                            if (count_value_r == TMW_MAX) begin
                                wave_nxt = !up_level;
                            end else if (match_ok) begin
                                wave_nxt = up_level;
                            end
                        end
                        default: wave_nxt = wave_out_r;
                    endcase
                end
                TMW_MODE_PHASE: begin
                    if (match_ok && act[1]) begin
                        if (count_value_r == TMW_MAX) begin
                            wave_nxt = !up_level;
                        end else if (count_value_r == TMW_BOTTOM) begin
                            wave_nxt = up_level;
                        end else if (dir_r == TMW_DIR_UP) begin
                            wave_nxt = up_level;
                        end else begin
                            wave_nxt = !up_level;
                        end
                    end
                end
                default: wave_nxt = wave_out_r;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wave_out_r <= 1'b0;
        end else begin
            wave_out_r <= wave_nxt;
        end
    end

    // =====================================================
    // pin and read port
    assign wave_out_o = wave_out_r;
    assign wave_oe_o = pin_dir_r && (act != TMW_ACT_NONE);
    assign overflow_flag_o = overflow_flag_r;
    assign compare_flag_o = compare_flag_r;

    always_comb begin
        case (reg_addr_i)
            TMW_ADDR_CTRL: rdata_nxt = {1'b0, ctrl_r.clk_sel, act, mode};
            TMW_ADDR_COUNT: rdata_nxt = count_value_r;
            TMW_ADDR_COMPARE: rdata_nxt = cmp_buf_r;
            TMW_ADDR_FLAGS: rdata_nxt = {6'h00, compare_flag_r, overflow_flag_r};
            TMW_ADDR_PINDIR: rdata_nxt = {7'h00, pin_dir_r};
            TMW_ADDR_STATUS: rdata_nxt = {6'h00, dir_r == TMW_DIR_DOWN, wave_out_r};
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= reg_rd_i ? rdata_nxt : 8'h00;
        end
    end

    assign reg_rdata_o = rdata_r;

    // =====================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    AST_NORMAL_WRAP: assert property (
        step && mode == TMW_MODE_NORMAL && !wr_ctrl && count_value_r == TMW_MAX
        |=> count_value_r == TMW_BOTTOM)
        else $error("normal mode did not wrap to zero");

    AST_NORMAL_OVF: assert property (
        step && mode == TMW_MODE_NORMAL && !wr_ctrl && count_value_r == TMW_MAX
        |=> overflow_flag_o && count_value_r == TMW_BOTTOM)
        else $error("overflow flag not set as count became zero");

    AST_COUNT_WRITE: assert property (
        wr_count |=> count_value_r == $past(reg_wdata_i))
        else $error("count write not taken");

    AST_CLEAR_ON_MATCH: assert property (
        step && mode == TMW_MODE_CLEAR && !wr_ctrl && match_ok
        |=> count_value_r == TMW_BOTTOM && compare_flag_o)
        else $error("count not cleared on match");

    AST_CLEAR_TOGGLE: assert property (
        step && mode == TMW_MODE_CLEAR && act == TMW_ACT_TOGGLE && match_ok && !wr_ctrl
        |=> wave_out_o != $past(wave_out_o))
        else $error("output did not toggle on match");

    AST_FAST_BOTTOM_SET: assert property (
        step && mode == TMW_MODE_FAST && act == TMW_ACT_CLEAR && !wr_ctrl
        && count_value_r == TMW_MAX
        |=> wave_out_o && count_value_r == TMW_BOTTOM)
        else $error("fast pwm output not set at bottom");

    AST_PHASE_TURN: assert property (
        step && mode == TMW_MODE_PHASE && !wr_ctrl && count_value_r == TMW_MAX
        |=> count_value_r == 8'hfe && dir_r == TMW_DIR_DOWN)
        else $error("phase correct did not turn at max");

    AST_PHASE_OVF: assert property (
        step && mode == TMW_MODE_PHASE && !wr_ctrl && dir_r == TMW_DIR_DOWN
        && count_value_r == TMW_ONE
        |=> count_value_r == TMW_BOTTOM && overflow_flag_o)
        else $error("phase correct overflow not set at bottom");

    AST_MATCH_FLAG: assert property (
        cmp_evt |=> compare_flag_o)
        else $error("compare flag missing after match");

    AST_PIN_GATE: assert property (
        !pin_dir_r |-> !wave_oe_o)
        else $error("output driven without direction bit");

    AST_NO_ACTION: assert property (
        act == TMW_ACT_NONE && !wr_ctrl |=> $stable(wave_out_o))
        else $error("output moved with action zero");

    COV_FAST_WRAP: cover property (step && mode == TMW_MODE_FAST && count_value_r == TMW_MAX);
    COV_PHASE_MAX: cover property (step && mode == TMW_MODE_PHASE && count_value_r == TMW_MAX);
    COV_CLEAR_MATCH: cover property (step && mode == TMW_MODE_CLEAR && match_ok);
    COV_FORCE: cover property (force_pulse && !pwm_mode && act != TMW_ACT_NONE);

endmodule

/* File: core/tmw_pkg.sv */
package tmw_pkg;

    // =====================================================
    // data and register map
    localparam int unsigned TMW_DATA_W = 8;
    localparam int unsigned TMW_ADDR_W = 3;
    localparam logic [2:0] TMW_ADDR_CTRL = 3'h0;
    localparam logic [2:0] TMW_ADDR_COUNT = 3'h1;
    localparam logic [2:0] TMW_ADDR_COMPARE = 3'h2;
    localparam logic [2:0] TMW_ADDR_FLAGS = 3'h3;
    localparam logic [2:0] TMW_ADDR_PINDIR = 3'h4;
    localparam logic [2:0] TMW_ADDR_STATUS = 3'h5;

    // =====================================================
    // field positions and reset values
    localparam int unsigned TMW_FORCE_BIT = 7;
    localparam int unsigned TMW_FLAG_OVF_BIT = 0;
    localparam int unsigned TMW_FLAG_CMP_BIT = 1;
    localparam int unsigned TMW_PINDIR_BIT = 0;
    localparam logic [7:0] TMW_COUNT_RST = 8'h00;
    localparam logic [7:0] TMW_COMPARE_RST = 8'h00;
    localparam logic [7:0] TMW_BOTTOM = 8'h00;
    localparam logic [7:0] TMW_MAX = 8'hff;
    localparam logic [7:0] TMW_ONE = 8'h01;

    // =====================================================
    // prescaler masks on the free-running divider
    localparam int unsigned TMW_DIV_W = 10;
    localparam logic [9:0] TMW_DIV8_MASK = 10'h007;
    localparam logic [9:0] TMW_DIV32_MASK = 10'h01f;
    localparam logic [9:0] TMW_DIV64_MASK = 10'h03f;
    localparam logic [9:0] TMW_DIV128_MASK = 10'h07f;
    localparam logic [9:0] TMW_DIV256_MASK = 10'h0ff;
    localparam logic [9:0] TMW_DIV1024_MASK = 10'h3ff;

    // =====================================================
    // modes, actions, direction
    typedef enum logic [1:0] {
        TMW_MODE_NORMAL = 2'b00,
        TMW_MODE_PHASE = 2'b01,
        TMW_MODE_CLEAR = 2'b10,
        TMW_MODE_FAST = 2'b11
    } tmw_mode_e;

    localparam logic [1:0] TMW_ACT_NONE = 2'b00;
    localparam logic [1:0] TMW_ACT_TOGGLE = 2'b01;
    localparam logic [1:0] TMW_ACT_CLEAR = 2'b10;
    localparam logic [1:0] TMW_ACT_SET = 2'b11;

    typedef enum logic {
        TMW_DIR_UP = 1'b0,
        TMW_DIR_DOWN = 1'b1
    } tmw_dir_e;

    typedef struct packed {
        logic force_cmp;
        logic [2:0] clk_sel;
        logic [1:0] out_action_sel;
        tmw_mode_e wave_mode_sel;
    } tmw_ctrl_s;

    localparam tmw_ctrl_s TMW_CTRL_RST = '{1'b0, 3'h0, 2'h0, TMW_MODE_NORMAL};

endpackage

/* File: core/tmw_prescaler.sv */
`timescale 1ns/100ps
module tmw_prescaler #(
    parameter int unsigned DIV_W = tmw_pkg::TMW_DIV_W
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [2:0] clk_sel_i,
    output logic tick_o
);
    import tmw_pkg::*;

    // =====================================================
    // free-running divider
    logic [DIV_W-1:0] div_r;
    logic [9:0] mask;

    initial begin
        if (DIV_W < 10) begin
            $error("divider too narrow for divide by 1024");
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_r <= '0;
        end else begin
            div_r <= DIV_W'(div_r + 1'b1);
        end
    end

    // select 0 stops the timer, 1 passes every clock
    always_comb begin
        mask = 10'h000;
        case (clk_sel_i)
            3'h2: mask = TMW_DIV8_MASK;
            3'h3: mask = TMW_DIV32_MASK;
            3'h4: mask = TMW_DIV64_MASK;
            3'h5: mask = TMW_DIV128_MASK;
            3'h6: mask = TMW_DIV256_MASK;
            3'h7: mask = TMW_DIV1024_MASK;
            default: mask = 10'h000;
        endcase
    end

    assign tick_o = (clk_sel_i != 3'h0) && ((div_r[9:0] & mask) == mask);

endmodule

/* File: sim/tmw_timer_test.sv */
`timescale 1ns/100ps
module tmw_timer_test;
    import tmw_pkg::*;

    // ==================================================
    // clock, reset, bus signals
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [TMW_ADDR_W-1:0] reg_addr_i = '0;
    logic [TMW_DATA_W-1:0] reg_wdata_i = '0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [TMW_DATA_W-1:0] reg_rdata_o;
    logic wave_out_o;
    logic wave_oe_o;
    logic overflow_flag_o;
    logic compare_flag_o;
    int failures = 0;
    int samples_checked = 0;

    always #10 clk_i = ~clk_i;

    tmw_timer dut (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .wave_out_o(wave_out_o),
        .wave_oe_o(wave_oe_o),
        .overflow_flag_o(overflow_flag_o),
        .compare_flag_o(compare_flag_o)
    );

    // ==================================================
    // bus and check tasks
    task automatic close_out;
        $display("counts: %0d checked, %0d failures", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    // cycles until wave_out_o changes; 1200 means it never did
    task automatic gap(output int n);
        logic s;
        // sample off the edge, the output is launched by it
        #1 s = wave_out_o;
        n = 0;
        do begin
            @(posedge clk_i);
            #1 n++;
        end while (wave_out_o === s && n < 1200);
    endtask

    task automatic sync_rise;
        int n;
        if (wave_out_o === 1'b1) begin
            gap(n);
        end
        gap(n);
    endtask

    // stop in normal mode first so compare lands directly in the active register
    task automatic run(input tmw_mode_e m, input logic [1:0] a, input logic [2:0] s,
                       input logic [7:0] c, input logic [7:0] cnt);
        tmw_ctrl_s cr;
        cr = TMW_CTRL_RST;
        wr(TMW_ADDR_CTRL, cr);
        wr(TMW_ADDR_COUNT, cnt);
        wr(TMW_ADDR_COMPARE, c);
        wr(TMW_ADDR_PINDIR, 8'h01);
        cr.clk_sel = s;
        cr.out_action_sel = a;
        cr.wave_mode_sel = m;
        wr(TMW_ADDR_CTRL, cr);
    endtask

    task automatic row(input tmw_mode_e m, input logic [1:0] a, input logic [2:0] s,
                       input logic [7:0] c, input int hi, input int lo, input logic [1:0] f);
        int n;
        logic [7:0] d;
        run(m, a, s, c, 8'h00);
        sync_rise;
        gap(n);
        chk("high time", hi, n);
        gap(n);
        chk("low time", lo, n);
        chk("pin enable", 1, wave_oe_o);
        wr(TMW_ADDR_FLAGS, 8'h03);
        repeat (520) @(posedge clk_i);
        rd(TMW_ADDR_FLAGS, d);
        chk("flags", f, d[1:0]);
        $display("row mode %0d action %0d select %0d done", m, a, s);
    endtask

    // ==================================================
    // tests
    initial begin
        #(20 * 60000);
        failures++;
        close_out;
    end

    initial begin
        int n;
        logic [7:0] d;
        logic w;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        wr(3'h6, 8'h5a);
        for (int i = 0; i < 8; i++) begin
            rd(i[2:0], d);
            chk("reset or unmapped read", 0, d);
        end
        $display("reset test done");
        run(TMW_MODE_NORMAL, TMW_ACT_NONE, 3'h1, 8'h00, 8'hf0);
        repeat (4) @(posedge clk_i);
        rd(TMW_ADDR_FLAGS, d);
        chk("overflow early", 0, d[0]);
        repeat (14) @(posedge clk_i);
        rd(TMW_ADDR_COUNT, d);
        chk("count wrapped", 1, d < 8'h20);
        wr(TMW_ADDR_COUNT, 8'h80);
        rd(TMW_ADDR_COUNT, d);
        chk("count load", 1, d >= 8'h80 && d <= 8'h83);
        rd(TMW_ADDR_FLAGS, d);
        chk("overflow sticky", 1, d[0]);
        wr(TMW_ADDR_FLAGS, 8'h01);
        rd(TMW_ADDR_FLAGS, d);
        chk("overflow cleared", 0, d[0]);
        $display("normal test done");
        run(TMW_MODE_CLEAR, TMW_ACT_TOGGLE, 3'h1, 8'h20, 8'h30);
        gap(n);
        chk("late match", 1, n >= 236 && n <= 246);
        $display("late compare test done");
        row(TMW_MODE_CLEAR, TMW_ACT_TOGGLE, 3'h1, 8'h09, 10, 10, 2'b10);
        row(TMW_MODE_CLEAR, TMW_ACT_TOGGLE, 3'h2, 8'h09, 80, 80, 2'b10);
        row(TMW_MODE_FAST, TMW_ACT_CLEAR, 3'h1, 8'h40, 65, 191, 2'b11);
        row(TMW_MODE_FAST, TMW_ACT_SET, 3'h1, 8'h40, 191, 65, 2'b11);
        row(TMW_MODE_FAST, TMW_ACT_CLEAR, 3'h1, 8'h00, 1, 255, 2'b11);
        row(TMW_MODE_FAST, TMW_ACT_TOGGLE, 3'h1, 8'h40, 256, 256, 2'b11);
        row(TMW_MODE_PHASE, TMW_ACT_CLEAR, 3'h1, 8'h40, 128, 382, 2'b11);
        row(TMW_MODE_PHASE, TMW_ACT_SET, 3'h1, 8'h40, 382, 128, 2'b11);
        // compare at max: bottom set wins over the match clear
        run(TMW_MODE_FAST, TMW_ACT_CLEAR, 3'h1, 8'hff, 8'h00);
        repeat (300) @(posedge clk_i);
        gap(n);
        chk("steady level", 1200, n);
        chk("steady high", 1, wave_out_o);
        // stopped in fast pwm: compare goes to the buffer, active stays at max
        wr(TMW_ADDR_CTRL, 8'h0b);
        wr(TMW_ADDR_COMPARE, 8'h10);
        wr(TMW_ADDR_COUNT, 8'h05);
        rd(TMW_ADDR_COMPARE, d);
        chk("compare buffer", 8'h10, d);
        wr(TMW_ADDR_CTRL, 8'h1b);
        gap(n);
        chk("buffered compare fall", 268, n);
        wr(TMW_ADDR_PINDIR, 8'h00);
        #1 chk("pin released", 0, wave_oe_o);
        run(TMW_MODE_CLEAR, TMW_ACT_NONE, 3'h1, 8'h05, 8'h00);
        #1 w = wave_out_o;
        repeat (300) @(posedge clk_i);
        chk("no action", w, wave_out_o);
        chk("no action enable", 0, wave_oe_o);
        // force strobe applies the stored action, so set it one write earlier
        wr(TMW_ADDR_CTRL, 8'h0e);
        wr(TMW_ADDR_CTRL, 8'h8e);
        rd(TMW_ADDR_STATUS, d);
        chk("forced set", 1, d[0]);
        wr(TMW_ADDR_CTRL, 8'h0a);
        wr(TMW_ADDR_CTRL, 8'h8a);
        rd(TMW_ADDR_STATUS, d);
        chk("forced clear", 0, d[0]);
        $display("extreme and action tests done");
        close_out;
    end
endmodule
